// ===== hdl/ppslc_pkg.sv
// constants for the port status and link capabilities register bank
package ppslc_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [7:0] PPSLC_OFF_CTRL_STATUS = 8'h70;
  localparam logic [7:0] PPSLC_OFF_LINK_CAPS = 8'h74;
  localparam logic [31:0] PPSLC_RESET_STATUS = 32'h0000_0000;
  localparam logic [3:0] PPSLC_RESET_CTRL_EN = 4'h0;
  // ****************
  // field positions
  // ****************
  localparam int PPSLC_ERR_LSB = 16;
  localparam int PPSLC_AUX_BIT = 20;
  localparam int PPSLC_PEND_BIT = 21;
  // ****************
  // capability defaults
  // ****************
  localparam logic [3:0] PPSLC_SPEED_DEF = 4'h2;
  localparam logic [1:0] PPSLC_ASPM_DEF = 2'h1;
  localparam logic [2:0] PPSLC_L0S_LAT = 3'h3;
  localparam logic [2:0] PPSLC_L1_LAT = 3'h0;
  localparam logic [5:0] PPSLC_WIDTH_X1 = 6'h01;
  localparam logic [5:0] PPSLC_WIDTH_X2 = 6'h02;
  localparam logic [5:0] PPSLC_WIDTH_X4 = 6'h04;
  localparam logic [7:0] PPSLC_UP_PORT_NUM = 8'h00;
  // loader word: [3:0] speed, [5:4] aspm, [8:6] l0s, [11:9] l1, [12] clkpm,
  // [13] bw notify, [21:14] port number
  localparam int PPSLC_LOAD_W = 22;

  function automatic logic [31:0] ppslc_cap_word(
    input logic [PPSLC_LOAD_W-1:0] ld,
    input logic [5:0] width,
    input logic dll_cap
  );
    ppslc_cap_word = {ld[21:14], 2'h0, ld[13], dll_cap, 1'b0, ld[12],
                      ld[11:9], ld[8:6], ld[5:4], width, ld[3:0]};
  endfunction : ppslc_cap_word
endpackage : ppslc_pkg

// ===== hdl/ppslc_err_flags.sv
// sticky write-one-to-clear error detected flags
`timescale 1ns/100ps
module ppslc_err_flags (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] err_detect,
  input wire logic [3:0] clear_mask,
  output logic [3:0] flags
);
  logic [3:0] flags_reg;
  logic [3:0] flags_next;

  always_comb begin
    flags_next = (flags_reg & ~clear_mask) | err_detect;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= 4'h0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;
endmodule : ppslc_err_flags

// ===== hdl/ppslc_port_regs.sv
// port device control/status and link capabilities register bank
`timescale 1ns/100ps
module ppslc_port_regs #(
  parameter logic IS_UPSTREAM = 1'b1,
  parameter logic [7:0] PORT_INDEX = 8'h01,
  parameter logic [5:0] LANE_WIDTH = 6'h04,
  parameter logic HOT_PLUG = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic [31:0] cfg_rdata,
  output logic cfg_done,
  input wire logic [3:0] err_detect,
  input wire logic aux_power,
  input wire logic load_valid,
  input wire logic [ppslc_pkg::PPSLC_LOAD_W-1:0] load_data,
  output logic [3:0] report_en
);
  // ****************
  // hardware defaults per port role
  // ****************
  localparam logic [7:0] PORT_NUM = IS_UPSTREAM ? ppslc_pkg::PPSLC_UP_PORT_NUM : PORT_INDEX;
  localparam logic CLKPM_DEF = IS_UPSTREAM;
  localparam logic BWN_DEF = ~IS_UPSTREAM;
  localparam logic DLL_CAP = ~IS_UPSTREAM & HOT_PLUG;
  localparam logic [ppslc_pkg::PPSLC_LOAD_W-1:0] LOAD_DEF = {PORT_NUM, BWN_DEF, CLKPM_DEF,
    ppslc_pkg::PPSLC_L1_LAT, ppslc_pkg::PPSLC_L0S_LAT, ppslc_pkg::PPSLC_ASPM_DEF,
    ppslc_pkg::PPSLC_SPEED_DEF};

  // ****************
  // state
  // ****************
  logic [ppslc_pkg::PPSLC_LOAD_W-1:0] load_reg;
  logic [ppslc_pkg::PPSLC_LOAD_W-1:0] load_next;
  logic [3:0] ctrl_en_reg;
  logic [3:0] ctrl_en_next;
  logic aux_reg;
  logic aux_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic done_reg;
  logic done_next;
  logic [3:0] err_flags;
  logic [3:0] clear_mask;
  logic [31:0] status_word;
  logic [31:0] caps_word;
  logic hit_status;
  logic hit_caps;

  ppslc_err_flags u_err_flags (
    .clk(clk),
    .rst(rst),
    .err_detect(err_detect),
    .clear_mask(clear_mask),
    .flags(err_flags)
  );

  always_comb begin
    hit_status = (cfg_addr == ppslc_pkg::PPSLC_OFF_CTRL_STATUS);
    hit_caps = (cfg_addr == ppslc_pkg::PPSLC_OFF_LINK_CAPS);
    clear_mask = 4'h0;
    if (cfg_wr && hit_status && cfg_be[2]) begin
      clear_mask = cfg_wdata[ppslc_pkg::PPSLC_ERR_LSB +: 4];
    end
    status_word = 32'h0000_0000;
    status_word[3:0] = ctrl_en_reg;
    status_word[ppslc_pkg::PPSLC_ERR_LSB +: 4] = err_flags;
    status_word[ppslc_pkg::PPSLC_AUX_BIT] = aux_reg;
    status_word[ppslc_pkg::PPSLC_PEND_BIT] = 1'b0;
    caps_word = ppslc_pkg::ppslc_cap_word(load_reg, LANE_WIDTH, DLL_CAP);
  end

  // ****************
  // register updates
  // ****************
  always_comb begin
    load_next = load_reg;
    if (load_valid) begin
      load_next = load_data;
    end
    ctrl_en_next = ctrl_en_reg;
    if (cfg_wr && hit_status && cfg_be[0]) begin
      ctrl_en_next = cfg_wdata[3:0];
    end
    aux_next = aux_power;
    done_next = cfg_rd | cfg_wr;
    rdata_next = 32'h0000_0000;
    if (cfg_rd && hit_status) begin
      rdata_next = status_word;
    end else if (cfg_rd && hit_caps) begin
      rdata_next = caps_word;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_reg <= LOAD_DEF;
      ctrl_en_reg <= ppslc_pkg::PPSLC_RESET_CTRL_EN;
      aux_reg <= 1'b0;
      rdata_reg <= ppslc_pkg::PPSLC_RESET_STATUS;
      done_reg <= 1'b0;
    end else begin
      load_reg <= load_next;
      ctrl_en_reg <= ctrl_en_next;
      aux_reg <= aux_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_done = done_reg;
  assign report_en = ctrl_en_reg;
endmodule : ppslc_port_regs

// ===== tb/ppslc_port_regs_chk.sv
// assertions on the port register bank
`timescale 1ns/100ps
module ppslc_chk #(parameter logic [5:0] LANE_WIDTH = 6'h04) (
  input logic clk, rst, cfg_rd, cfg_wr, cfg_done, aux_power,
  input logic [7:0] cfg_addr,
  input logic [31:0] cfg_wdata, cfg_rdata,
  input logic [3:0] cfg_be, err_detect, report_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire r70 = cfg_rd && cfg_addr == 8'h70;
  wire w70 = cfg_wr && cfg_addr == 8'h70;
  a_done_pulse: assert property (cfg_done == $past(cfg_rd | cfg_wr)) else $error("done");
  a_pend_zero: assert property (r70 |=> cfg_rdata[31:21] == 11'h000) else $error("pend");
  a_aux_mirror: assert property (r70 && $stable(aux_power) |=>
    cfg_rdata[20] == $past(aux_power)) else $error("aux");
  a_err_log: assert property ((|err_detect) ##1 r70 |=>
    (cfg_rdata[19:16] & $past(err_detect, 2)) == $past(err_detect, 2)) else $error("log");
  a_w1c_clear: assert property (w70 && cfg_be[2] && cfg_wdata[16] && !err_detect[0]
    ##1 r70 && !err_detect[0] |=> !cfg_rdata[16]) else $error("w1c");
  a_en_write: assert property (w70 && cfg_be[0] |=>
    report_en == $past(cfg_wdata[3:0])) else $error("enable");
  a_caps_fixed: assert property (cfg_rd && cfg_addr == 8'h74 |=>
    cfg_rdata[9:4] == LANE_WIDTH && cfg_rdata[23:22] == 2'h0) else $error("caps");
  a_unmapped: assert property (cfg_rd && !r70 && cfg_addr != 8'h74 |=>
    cfg_rdata == 32'h0000_0000) else $error("unmapped");
endmodule : ppslc_chk
bind ppslc_port_regs ppslc_chk #(.LANE_WIDTH(LANE_WIDTH)) u_chk (.*);

// ===== tb/ppslc_host.sv
// host model issuing configuration reads and writes
`timescale 1ns/100ps
module ppslc_host (input logic clk, cfg_done, input logic [31:0] cfg_rdata,
  output logic cfg_rd = 0, cfg_wr = 0, output logic [7:0] cfg_addr = 0,
  output logic [31:0] cfg_wdata = 0, output logic [3:0] cfg_be = 0);
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] b,
                      output logic [32:0] q);
    @(negedge clk);
    {cfg_rd, cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {!w, w, a, d, b};
    @(negedge clk);
    {cfg_rd, cfg_wr} = 2'h0;
    {cfg_addr, cfg_wdata} = ~{a, d};
    q = {cfg_done, cfg_rdata};
  endtask : xfer
endmodule : ppslc_host

// ===== tb/tb_ppslc_port_regs.sv
// self-checking bench for the port register bank
`timescale 1ns/100ps
module tb_ppslc_port_regs;
  logic clk = 0, rst = 1, aux_power = 0, load_valid = 0, cfg_rd, cfg_wr, cfg_done;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, s = 10, e, m;
  logic [3:0] cfg_be, report_en, err_detect = 0;
  logic [21:0] load_data = 0;
  logic [32:0] q;
  int miscompares = 0, checked = 0;
  ppslc_port_regs dut (.*);
  ppslc_host host (.*);
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [31:0] caps(logic [21:0] l);
    return {l[21:14], 2'h0, l[13], 2'h0, l[12], l[11:4], 6'h04, l[3:0]};
  endfunction : caps
  task automatic chk(logic [32:0] g, logic [32:0] x);
    checked++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task wrap_up;
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    host.xfer(0, 8'h74, 0, 0, q);
    chk(q, 33'h1_0004_3442);
    host.xfer(1, 8'h74, xs(), 4'hF, q);
    host.xfer(0, 8'h74, 0, 0, q);
    chk(q, 33'h1_0004_3442);
    aux_power = 1;
    host.xfer(1, 8'h70, 32'hFFFF_FFFF, 4'hF, q);
    host.xfer(0, 8'h70, 0, 0, q);
    chk(q, 33'h1_0010_000F);
    chk({29'h0000_0000, report_en}, 33'h0_0000_000F);
    host.xfer(1, 8'h70, 0, 4'h1, q);
    e = 32'h0010_0000;
    repeat (8) begin
      m = xs();
      err_detect = m[3:0];
      @(negedge clk);
      err_detect = 0;
      e[19:16] |= m[3:0];
      host.xfer(0, 8'h70, 0, 0, q);
      chk(q, {1'b1, e});
      host.xfer(1, 8'h70, m, 4'h4, q);
      e[19:16] &= ~m[19:16];
      host.xfer(0, 8'h70, 0, 0, q);
      chk(q, {1'b1, e});
    end
    host.xfer(0, 8'h78, 0, 0, q);
    chk(q, 33'h1_0000_0000);
    m = xs();
    load_data = m[21:0];
    load_valid = 1;
    @(negedge clk);
    load_valid = 0;
    host.xfer(0, 8'h74, 0, 0, q);
    chk(q, {1'b1, caps(m[21:0])});
    wrap_up;
  end
endmodule : tb_ppslc_port_regs
